// ---- verilog/stl_torque_limit.sv ----
// torque limit selection: parameter store, analog limit path, saturation
`timescale 1ns/1ps
`include "stl_defs.svh"
module stl_torque_limit
   import stl_pkg::*;
#(
   parameter int NUM_TERMS   = 8,
   parameter int TICK_CYCLES = `STL_TICK_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 param_wr,
   input  stl_param_t                param_sel,
   input  wire logic [15:0]          param_wdata,
   output logic                      param_err,
   input  wire logic                 restart_req,
   input  stl_ctrl_mode_t            ctrl_mode,
   input  wire logic [9:0]           motor_max_torque,
   input  wire logic [NUM_TERMS-1:0] term_in,
   input  wire logic signed [15:0]   analog_ref_mv,
   input  wire logic signed [15:0]   torque_cmd_in,
   output logic signed [15:0]        torque_cmd_out,
   output logic [9:0]                fwd_limit,
   output logic [9:0]                rev_limit,
   output logic [9:0]                analog_limit,
   output logic                      analog_mode_active,
   output logic                      ctrl_tick
);
   localparam int DW = 34;
   localparam int FB = `STL_FRAC_BITS;
   localparam int TW = $clog2(TICK_CYCLES + 1);

   generate
      if (NUM_TERMS < 1 || NUM_TERMS > 16) begin : g_bad_terms
         $error("stl_torque_limit: NUM_TERMS must be 1 to 16");
      end
      if (TICK_CYCLES < 2 * DW + 8) begin : g_bad_tick
         $error("stl_torque_limit: TICK_CYCLES too short for two divisions");
      end
   endgenerate

   // parameter store
   logic [9:0]  internal_fwd_limit_q;
   logic [9:0]  internal_rev_limit_q;
   logic [9:0]  external_fwd_limit_q;
   logic [9:0]  external_rev_limit_q;
   logic [6:0]  analog_ref_gain_q;
   logic [15:0] analog_ref_filter_tc_q;
   logic [3:0]  function_select_app_q;
   logic [7:0]  input_allocation_cfg_q;

   // write range checks; a refused write leaves the parameter untouched
   wire limit_ok = (param_wdata <= 16'(`STL_LIMIT_MAX));
   wire gain_ok  = (param_wdata >= 16'(`STL_GAIN_MIN)) &&
                   (param_wdata <= 16'(`STL_GAIN_MAX));
   wire fsel_ok  = (param_wdata <= 16'h000F);
   wire alloc_ok = (param_wdata <= 16'h00FF);

   logic wr_ok;
   always_comb begin
      case (param_sel)
         STL_P_INT_FWD,
         STL_P_INT_REV,
         STL_P_EXT_FWD,
         STL_P_EXT_REV:   wr_ok = limit_ok;
         STL_P_GAIN:      wr_ok = gain_ok;
         STL_P_FILTER_TC: wr_ok = 1'b1;
         STL_P_FUNC_SEL:  wr_ok = fsel_ok;
         STL_P_ALLOC:     wr_ok = alloc_ok;
         default:         wr_ok = 1'b0;
      endcase
   end

   wire do_wr = param_wr && wr_ok;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         internal_fwd_limit_q <= `STL_INT_LIMIT_RST;
         internal_rev_limit_q <= `STL_INT_LIMIT_RST;
         external_fwd_limit_q <= `STL_EXT_LIMIT_RST;
         external_rev_limit_q <= `STL_EXT_LIMIT_RST;
      end else if (do_wr) begin
         case (param_sel)
            STL_P_INT_FWD: internal_fwd_limit_q <= param_wdata[9:0];
            STL_P_INT_REV: internal_rev_limit_q <= param_wdata[9:0];
            STL_P_EXT_FWD: external_fwd_limit_q <= param_wdata[9:0];
            STL_P_EXT_REV: external_rev_limit_q <= param_wdata[9:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         analog_ref_gain_q      <= `STL_GAIN_RST;
         analog_ref_filter_tc_q <= `STL_TC_RST;
         function_select_app_q  <= `STL_FSEL_RST;
         input_allocation_cfg_q <= `STL_ALLOC_RST;
      end else if (do_wr) begin
         case (param_sel)
            STL_P_GAIN:      analog_ref_gain_q      <= param_wdata[6:0];
            STL_P_FILTER_TC: analog_ref_filter_tc_q <= param_wdata;
            STL_P_FUNC_SEL:  function_select_app_q  <= param_wdata[3:0];
            STL_P_ALLOC:     input_allocation_cfg_q <= param_wdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         param_err <= 1'b0;
      end else begin
         // one pulse per refused write, so back-to-back refusals stay countable
         param_err <= param_wr && !wr_ok;
      end
   end

   // analog mode only changes at a restart, never on the write itself
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         analog_mode_active <= 1'b0;
      end else if (restart_req) begin
         analog_mode_active <= (function_select_app_q == `STL_FSEL_ANALOG);
      end
   end

   // input allocation: an index past the last terminal reads as open
   wire [15:0] term_pad = 16'(term_in);
   wire [3:0]  fwd_idx  = input_allocation_cfg_q[`STL_ALLOC_FWD_LSB +: `STL_ALLOC_FLD_W];
   wire [3:0]  rev_idx  = input_allocation_cfg_q[`STL_ALLOC_REV_LSB +: `STL_ALLOC_FLD_W];
   wire        fwd_ext_limit_in = term_pad[fwd_idx];
   wire        rev_ext_limit_in = term_pad[rev_idx];

   // control cycle tick
   // the tick is also the filter step, so the time constant scales with TICK_CYCLES
   logic [TW-1:0] tick_cnt_q;
   wire           tick_wrap = (tick_cnt_q == TW'(TICK_CYCLES - 1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= '0;
         ctrl_tick  <= 1'b0;
      end else begin
         tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TW'(1);
         ctrl_tick  <= tick_wrap;
      end
   end

   // analog path: filter, then magnitude over gain, one shared divider
   stl_state_t state_q;
   logic signed [31:0] filt_q;
   logic signed [15:0] sample_q;

   logic          div_start;
   logic          div_done;
   logic [DW-1:0] div_num;
   logic [DW-1:0] div_den;
   logic [DW-1:0] div_quot;

   // the divider loads on the tick edge itself, when sample_q still holds the last tick's value
   wire signed [15:0] x_now     = (state_q == STL_S_IDLE) ? analog_ref_mv : sample_q;
   // fractional state keeps the filter from stalling short of the input
   wire signed [32:0] filt_diff = {x_now[15], x_now, {FB{1'b0}}} - {filt_q[31], filt_q};
   wire               diff_neg  = filt_diff[32];
   wire [32:0]        diff_mag  = diff_neg ? 33'(-filt_diff) : filt_diff;
   wire [16:0]        tc_den    = {1'b0, analog_ref_filter_tc_q} + 17'h0_0001;
   // time constant zero divides by one, so the output follows the input at once
   wire signed [31:0] filt_new  = diff_neg ? filt_q - div_quot[31:0] : filt_q + div_quot[31:0];

   wire signed [15:0] filt_int  = filt_new[31:FB];
   wire [16:0]        filt_mag  = filt_int[15] ? 17'(-{filt_int[15], filt_int}) : 17'(filt_int);

   wire [DW-1:0] filt_num  = DW'(diff_mag);
   wire [DW-1:0] filt_dnm  = DW'(tc_den);
   wire [DW-1:0] lim_num   = DW'(filt_mag);
   wire [DW-1:0] lim_dnm   = DW'(analog_ref_gain_q);
   // mV over gain in 0.1 V steps gives percent of rated torque
   wire [9:0]    lim_sat   = (div_quot > DW'(`STL_LIMIT_MAX)) ? `STL_LIMIT_MAX : div_quot[9:0];

   assign div_start = ((state_q == STL_S_IDLE) && ctrl_tick) ||
                      ((state_q == STL_S_FILT) && div_done);
   assign div_num   = (state_q == STL_S_FILT) ? lim_num : filt_num;
   assign div_den   = (state_q == STL_S_FILT) ? lim_dnm : filt_dnm;

   // one divider for both steps: the tick period must cover two full divisions
   stl_divider #(
      .W (DW)
   ) u_div (
      .clk    (clk),
      .resetn (resetn),
      .start  (div_start),
      .num    (div_num),
      .den    (div_den),
      .done   (div_done),
      .quot   (div_quot)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sample_q <= '0;
      end else if (ctrl_tick && state_q == STL_S_IDLE) begin
         sample_q <= analog_ref_mv;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q      <= STL_S_IDLE;
         filt_q       <= '0;
         analog_limit <= '0;
      end else begin
         case (state_q)
            STL_S_IDLE: begin
               if (ctrl_tick) begin
                  state_q <= STL_S_FILT;
               end
            end
            STL_S_FILT: begin
               if (div_done) begin
                  filt_q  <= filt_new;
                  state_q <= STL_S_LIMIT;
               end
            end
            STL_S_LIMIT: begin
               if (div_done) begin
                  analog_limit <= lim_sat;
                  state_q      <= STL_S_IDLE;
               end
            end
            default: state_q <= STL_S_IDLE;
         endcase
      end
   end

   // torque control has its reference on the same input, so no analog limit there
   wire analog_on = analog_mode_active && (ctrl_mode == STL_MODE_SPEED);

   // one magnitude serves both directions
   stl_dir_limit #(
      .LW (10)
   ) u_fwd (
      .clk          (clk),
      .resetn       (resetn),
      .internal_lim (internal_fwd_limit_q),
      .external_lim (external_fwd_limit_q),
      .ext_on       (fwd_ext_limit_in),
      .analog_lim   (analog_limit),
      .analog_on    (analog_on),
      .motor_max    (motor_max_torque),
      .lim_q        (fwd_limit)
   );

   stl_dir_limit #(
      .LW (10)
   ) u_rev (
      .clk          (clk),
      .resetn       (resetn),
      .internal_lim (internal_rev_limit_q),
      .external_lim (external_rev_limit_q),
      .ext_on       (rev_ext_limit_in),
      .analog_lim   (analog_limit),
      .analog_on    (analog_on),
      .motor_max    (motor_max_torque),
      .lim_q        (rev_limit)
   );

   // saturation, once per control cycle
   // a limit change between ticks reaches the output only at the next tick
   wire signed [16:0] cmd_ext = {torque_cmd_in[15], torque_cmd_in};
   wire signed [16:0] pos_lim = $signed({7'h00, fwd_limit});
   wire signed [16:0] neg_lim = -$signed({7'h00, rev_limit});
   wire signed [16:0] cmd_sat = (cmd_ext > pos_lim) ? pos_lim :
                                (cmd_ext < neg_lim) ? neg_lim : cmd_ext;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         torque_cmd_out <= '0;
      end else if (ctrl_tick) begin
         torque_cmd_out <= cmd_sat[15:0];
      end
   end

endmodule // stl_torque_limit

// ---- verilog/stl_defs.svh ----
// constants for the torque limit selection block
`ifndef STL_DEFS_SVH
`define STL_DEFS_SVH

// limit parameters, 1 % of rated torque per step
`define STL_LIMIT_MAX       10'h320
`define STL_INT_LIMIT_RST   10'h320
`define STL_EXT_LIMIT_RST   10'h064

// analog reference gain, 0.1 V per step
`define STL_GAIN_MIN        7'h0A
`define STL_GAIN_MAX        7'h64
`define STL_GAIN_RST        7'h1E

// filter time constant, 0.01 ms per step
`define STL_TC_RST          16'h0000
`define STL_TC_UNIT_NS      10000
`define STL_CLK_PERIOD_NS   20
`define STL_TICK_CYCLES     ((`STL_TC_UNIT_NS + `STL_CLK_PERIOD_NS - 1) / `STL_CLK_PERIOD_NS)
`define STL_FRAC_BITS       16

// function select digit
`define STL_FSEL_RST        4'h0
`define STL_FSEL_ANALOG     4'h1

// input allocation: terminal index per signal, unused index means not allocated
`define STL_ALLOC_RST       8'h65
`define STL_ALLOC_FWD_LSB   0
`define STL_ALLOC_REV_LSB   4
`define STL_ALLOC_FLD_W     4

`endif

// ---- verilog/stl_pkg.sv ----
// types for the torque limit selection block
package stl_pkg;

   typedef enum logic [1:0] {
      STL_MODE_SPEED,
      STL_MODE_POSITION,
      STL_MODE_TORQUE
   } stl_ctrl_mode_t;

   typedef enum logic [2:0] {
      STL_P_INT_FWD,
      STL_P_INT_REV,
      STL_P_EXT_FWD,
      STL_P_EXT_REV,
      STL_P_GAIN,
      STL_P_FILTER_TC,
      STL_P_FUNC_SEL,
      STL_P_ALLOC
   } stl_param_t;

   typedef enum {
      STL_S_IDLE,
      STL_S_FILT,
      STL_S_LIMIT
   } stl_state_t;

endpackage

// ---- verilog/stl_divider.sv ----
// serial restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`include "stl_defs.svh"
module stl_divider #(
   parameter int W = 34
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         start,
   input  wire logic [W-1:0] num,
   input  wire logic [W-1:0] den,
   output logic              done,
   output logic [W-1:0]      quot
);
   localparam int CW = $clog2(W + 1);

   generate
      if (W < 2) begin : g_bad_w
         $error("stl_divider: W must be at least 2");
      end
   endgenerate

   logic [W:0]    rem_q;
   logic [W-1:0]  den_q;
   logic [CW-1:0] cnt_q;
   logic          busy_q;

   wire  [W:0]    shifted = {rem_q[W-1:0], quot[W-1]};
   wire  [W:0]    trial   = shifted - {1'b0, den_q};
   wire           fits    = ~trial[W];
   wire           last    = busy_q && (cnt_q == CW'(1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rem_q  <= '0;
         den_q  <= '0;
         quot   <= '0;
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done   <= 1'b0;
      end else if (start) begin
         rem_q  <= '0;
         den_q  <= den;
         quot   <= num;
         cnt_q  <= CW'(W);
         busy_q <= 1'b1;
         done   <= 1'b0;
      end else begin
         done <= last;
         if (busy_q) begin
            rem_q  <= fits ? trial : shifted;
            quot   <= {quot[W-2:0], fits};
            cnt_q  <= cnt_q - CW'(1);
            busy_q <= ~last;
         end
      end
   end
endmodule // stl_divider

// ---- verilog/stl_dir_limit.sv ----
// effective torque limit for one direction
`timescale 1ns/1ps
`include "stl_defs.svh"
module stl_dir_limit #(
   parameter int LW = 10
) (
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic [LW-1:0] internal_lim,
   input  wire logic [LW-1:0] external_lim,
   input  wire logic          ext_on,
   input  wire logic [LW-1:0] analog_lim,
   input  wire logic          analog_on,
   input  wire logic [LW-1:0] motor_max,
   output logic [LW-1:0]      lim_q
);
   generate
      if (LW < 10) begin : g_bad_lw
         $error("stl_dir_limit: LW too narrow for 800 percent");
      end
   endgenerate

   wire [LW-1:0] with_ext = (ext_on && external_lim < internal_lim) ? external_lim : internal_lim;
   wire [LW-1:0] with_ana = (analog_on && analog_lim < with_ext) ? analog_lim : with_ext;
   // a setting above what the motor can deliver falls back to the motor maximum
   wire [LW-1:0] lim_d    = (with_ana > motor_max) ? motor_max : with_ana;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lim_q <= `STL_INT_LIMIT_RST;
      end else begin
         lim_q <= lim_d;
      end
   end
endmodule // stl_dir_limit

// ---- bench/stl_torque_limit_checker.sv ----
// assertion checker for the torque limit selection block
`timescale 1ns/1ps
module stl_torque_limit_checker
   import stl_pkg::*;
#(
   parameter int NUM_TERMS   = 8,
   parameter int TICK_CYCLES = 500
) (
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic                 param_wr,
   input stl_param_t                param_sel,
   input wire logic [15:0]          param_wdata,
   input wire logic                 param_err,
   input wire logic                 restart_req,
   input stl_ctrl_mode_t            ctrl_mode,
   input wire logic [9:0]           motor_max_torque,
   input wire logic [NUM_TERMS-1:0] term_in,
   input wire logic signed [15:0]   torque_cmd_in,
   input wire logic signed [15:0]   torque_cmd_out,
   input wire logic [9:0]           fwd_limit,
   input wire logic [9:0]           rev_limit,
   input wire logic [9:0]           analog_limit,
   input wire logic                 analog_mode_active,
   input wire logic                 ctrl_tick
);
   logic [9:0]  if_q, ir_q, ef_q, er_q;
   logic [7:0]  al_q;
   logic [3:0]  fs_q;
   logic [15:0] cnt_q;
   logic        seen_q;
   logic        live_q;
   function automatic logic [9:0] lo(input logic [9:0] a, input logic [9:0] b);
      return (a < b) ? a : b;
   endfunction
   wire logic lim_w = param_sel inside {STL_P_INT_FWD, STL_P_INT_REV, STL_P_EXT_FWD, STL_P_EXT_REV};
   wire logic gain_w = param_sel == STL_P_GAIN && (param_wdata < 16'h000A || param_wdata > 16'h0064);
   wire logic bad_w = param_wr && ((lim_w && param_wdata > 16'h0320) || gain_w
                      || (param_sel == STL_P_FUNC_SEL && param_wdata > 16'h000F)
                      || (param_sel == STL_P_ALLOC && param_wdata > 16'h00FF));
   wire logic fon_w = al_q[3:0] < NUM_TERMS && term_in[al_q[3:0]];
   wire logic ron_w = al_q[7:4] < NUM_TERMS && term_in[al_q[7:4]];
   // analog cap left out of speed-only reading when torque or position mode
   wire logic [9:0] cap_w = lo(motor_max_torque, (analog_mode_active && ctrl_mode == STL_MODE_SPEED) ? analog_limit : 10'h3FF);
   wire logic [9:0] bf_w = lo(lo(if_q, fon_w ? ef_q : 10'h3FF), cap_w);
   wire logic [9:0] br_w = lo(lo(ir_q, ron_w ? er_q : 10'h3FF), cap_w);
   wire logic signed [15:0] pf_w = $signed({6'h00, fwd_limit});
   wire logic signed [15:0] nr_w = -$signed({6'h00, rev_limit});
   wire logic signed [15:0] sat_w = torque_cmd_in > pf_w ? pf_w : (torque_cmd_in < nr_w ? nr_w : torque_cmd_in);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {if_q, ir_q, ef_q, er_q} <= {10'h320, 10'h320, 10'h064, 10'h064};
         al_q <= 8'h65;
         fs_q <= 4'h0;
      end else if (param_wr && !bad_w) begin
         case (param_sel)
            STL_P_INT_FWD: if_q <= param_wdata[9:0];
            STL_P_INT_REV: ir_q <= param_wdata[9:0];
            STL_P_EXT_FWD: ef_q <= param_wdata[9:0];
            STL_P_EXT_REV: er_q <= param_wdata[9:0];
            STL_P_FUNC_SEL: fs_q <= param_wdata[3:0];
            STL_P_ALLOC: al_q <= param_wdata[7:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 16'h0000;
         seen_q <= 1'b0;
         live_q <= 1'b0;
      end else begin
         cnt_q <= ctrl_tick ? 16'h0000 : cnt_q + 16'h0001;
         seen_q <= seen_q | ctrl_tick;
         // limits at the first edge after release still show reset values
         live_q <= 1'b1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_tick;
      ctrl_tick;
   endsequence
   sequence s_restart;
      restart_req;
   endsequence
   property p_fwd_lim;
      live_q |=> fwd_limit == $past(bf_w);
   endproperty
   a_fwd_lim: assert property (p_fwd_lim) else $error("forward limit wrong");
   property p_rev_lim;
      live_q |=> rev_limit == $past(br_w);
   endproperty
   a_rev_lim: assert property (p_rev_lim) else $error("reverse limit wrong");
   property p_sat;
      s_tick |=> torque_cmd_out == $past(sat_w);
   endproperty
   a_sat: assert property (p_sat) else $error("saturated command wrong");
   property p_out_hold;
      !ctrl_tick |=> $stable(torque_cmd_out);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("command moved between ticks");
   property p_tick_gap;
      seen_q |-> ctrl_tick == (cnt_q == TICK_CYCLES - 1);
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("control tick spacing wrong");
   property p_restart;
      s_restart |=> analog_mode_active == $past(fs_q == 4'h1);
   endproperty
   a_restart: assert property (p_restart) else $error("mode not loaded at restart");
   property p_mode_hold;
      !restart_req |=> $stable(analog_mode_active);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without restart");
   property p_err;
      1'b1 |=> param_err == $past(bad_w);
   endproperty
   a_err: assert property (p_err) else $error("write refusal wrong");
   property p_an_range;
      analog_limit <= 10'h320;
   endproperty
   a_an_range: assert property (p_an_range) else $error("analog limit above range");
endmodule // stl_torque_limit_checker

bind stl_torque_limit stl_torque_limit_checker #(.NUM_TERMS(NUM_TERMS), .TICK_CYCLES(TICK_CYCLES)) i_chk (
   .clk(clk), .resetn(resetn), .param_wr(param_wr), .param_sel(param_sel), .param_wdata(param_wdata),
   .param_err(param_err), .restart_req(restart_req), .ctrl_mode(ctrl_mode), .motor_max_torque(motor_max_torque),
   .term_in(term_in), .torque_cmd_in(torque_cmd_in), .torque_cmd_out(torque_cmd_out), .fwd_limit(fwd_limit),
   .rev_limit(rev_limit), .analog_limit(analog_limit), .analog_mode_active(analog_mode_active), .ctrl_tick(ctrl_tick));

// ---- bench/stl_host_model.sv ----
// host controller model: limit input terminals and analog reference
`timescale 1ns/1ps
module stl_host_model #(
   parameter int NUM_TERMS = 8
) (
   input  wire logic                 clk,
   input  wire logic                 fwd_req,
   input  wire logic                 rev_req,
   input  wire logic [7:0]           alloc,
   input  wire logic signed [15:0]   mv_req,
   output logic [NUM_TERMS-1:0]      term_in,
   output logic signed [15:0]        analog_ref_mv
);
   integer seed = 32'h41a0;
   initial term_in = '0;
   initial analog_ref_mv = 16'h0000;
   always @(posedge clk) begin : drive
      logic [NUM_TERMS-1:0] t;
      // free terminals wander so a wrong allocation shows up
      t = NUM_TERMS'($random(seed));
      if (alloc[3:0] < NUM_TERMS) t[alloc[3:0]] = fwd_req;
      if (alloc[7:4] < NUM_TERMS) t[alloc[7:4]] = rev_req;
      term_in <= t;
      analog_ref_mv <= mv_req;
   end
endmodule // stl_host_model

// ---- bench/servo_torque_limit_select_bench.sv ----
// self-checking bench for the torque limit selection block
`timescale 1ns/1ps
module servo_torque_limit_select_bench
   import stl_pkg::*;
;
   localparam int TICKS = 80;
   logic               clk, resetn, param_wr, restart_req, fwd_on, rev_on;
   stl_param_t         param_sel;
   stl_ctrl_mode_t     ctrl_mode;
   logic [15:0]        param_wdata;
   logic [9:0]         motor_max_torque, int_f, int_r, ext_f, ext_r, exp_f, exp_r;
   logic [7:0]         alloc, term_in;
   logic signed [15:0] mv, analog_ref_mv, torque_cmd_in;
   wire logic          param_err, analog_mode_active, ctrl_tick;
   wire logic [15:0]   torque_cmd_out;
   wire logic [9:0]    fwd_limit, rev_limit, analog_limit;
   integer             seed = 32'h41a0;
   integer             miscompares = 0;
   integer             n_tests = 0;
   integer             i;
   stl_torque_limit #(.NUM_TERMS(8), .TICK_CYCLES(TICKS)) i_dut (.clk(clk), .resetn(resetn), .param_wr(param_wr),
      .param_sel(param_sel), .param_wdata(param_wdata), .param_err(param_err), .restart_req(restart_req),
      .ctrl_mode(ctrl_mode), .motor_max_torque(motor_max_torque), .term_in(term_in), .analog_ref_mv(analog_ref_mv),
      .torque_cmd_in(torque_cmd_in), .torque_cmd_out(torque_cmd_out), .fwd_limit(fwd_limit), .rev_limit(rev_limit),
      .analog_limit(analog_limit), .analog_mode_active(analog_mode_active), .ctrl_tick(ctrl_tick));
   stl_host_model #(.NUM_TERMS(8)) i_host (.clk(clk), .fwd_req(fwd_on), .rev_req(rev_on), .alloc(alloc),
      .mv_req(mv), .term_in(term_in), .analog_ref_mv(analog_ref_mv));
   always #10 clk = ~clk;
   function automatic int rnd(input int n);
      return {$random(seed)} % n;
   endfunction
   function automatic logic [9:0] lo(input logic [9:0] a, input logic [9:0] b);
      return (a < b) ? a : b;
   endfunction
   function automatic logic [15:0] clamp(input logic signed [15:0] c, input logic [9:0] f, input logic [9:0] r);
      if (c > $signed({6'h00, f})) return {6'h00, f};
      if (c < -$signed({6'h00, r})) return -$signed({6'h00, r});
      return c;
   endfunction
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input stl_param_t s, input logic [15:0] d, input logic err);
      @(posedge clk);
      param_wr <= 1'b1;
      param_sel <= s;
      param_wdata <= d;
      @(posedge clk);
      param_wr <= 1'b0;
      #1;
      cmp({15'h0000, param_err}, {15'h0000, err});
   endtask
   task automatic restart(input logic exp);
      @(posedge clk);
      restart_req <= 1'b1;
      @(posedge clk);
      restart_req <= 1'b0;
      #1;
      cmp({15'h0000, analog_mode_active}, {15'h0000, exp});
   endtask
   // an: analog cap expected in force, all ones when none
   task automatic chk_lim(input logic [9:0] an);
      settle(3);
      exp_f = lo(lo(int_f, (fwd_on && alloc[3:0] < 8) ? ext_f : 10'h3FF), lo(motor_max_torque, an));
      exp_r = lo(lo(int_r, (rev_on && alloc[7:4] < 8) ? ext_r : 10'h3FF), lo(motor_max_torque, an));
      cmp({6'h00, fwd_limit}, {6'h00, exp_f});
      cmp({6'h00, rev_limit}, {6'h00, exp_r});
   endtask
   task automatic wait_tick;
      for (int k = 0; k < 4 * TICKS && ctrl_tick !== 1'b1; k++) @(negedge clk);
      if (ctrl_tick !== 1'b1) begin
         miscompares++;
         stop_test();
      end
      settle(1);
   endtask
   initial begin
      {clk, resetn, param_wr, restart_req, fwd_on, rev_on} = 6'h00;
      param_sel = STL_P_INT_FWD;
      param_wdata = 16'h0000;
      ctrl_mode = STL_MODE_SPEED;
      motor_max_torque = 10'h12C;
      {int_f, int_r, ext_f, ext_r} = {10'h320, 10'h320, 10'h064, 10'h064};
      alloc = 8'h65;
      mv = 16'h0000;
      torque_cmd_in = 16'h0000;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      chk_lim(10'h3FF);
      @(posedge clk);
      {motor_max_torque, fwd_on, rev_on} <= {10'h3FF, 2'b11};
      chk_lim(10'h3FF);
      wr(STL_P_INT_FWD, 16'h0321, 1'b1);
      wr(STL_P_GAIN, 16'h0009, 1'b1);
      wr(STL_P_GAIN, 16'h0065, 1'b1);
      wr(STL_P_GAIN, 16'h000A, 1'b0);
      wr(STL_P_GAIN, 16'h0064, 1'b0);
      wr(STL_P_GAIN, 16'h001E, 1'b0);
      for (i = 0; i < 16; i++) begin
         int_f = (i == 0) ? 10'h000 : 10'(rnd(801));
         int_r = (i == 0) ? 10'h320 : 10'(rnd(801));
         ext_f = 10'(rnd(801));
         ext_r = 10'(rnd(801));
         wr(STL_P_INT_FWD, {6'h00, int_f}, 1'b0);
         wr(STL_P_INT_REV, {6'h00, int_r}, 1'b0);
         wr(STL_P_EXT_FWD, {6'h00, ext_f}, 1'b0);
         wr(STL_P_EXT_REV, {6'h00, ext_r}, 1'b0);
         @(posedge clk);
         motor_max_torque <= 10'(rnd(1024));
         {fwd_on, rev_on} <= 2'(rnd(4));
         torque_cmd_in <= 16'(rnd(2001) - 1000);
         chk_lim(10'h3FF);
         wait_tick();
         cmp(torque_cmd_out, clamp(torque_cmd_in, exp_f, exp_r));
      end
      @(posedge clk);
      {fwd_on, rev_on} <= 2'b11;
      wr(STL_P_ALLOC, 16'h0021, 1'b0);
      alloc = 8'h21;
      chk_lim(10'h3FF);
      wr(STL_P_ALLOC, 16'h00FF, 1'b0);
      alloc = 8'hFF;
      chk_lim(10'h3FF);
      wr(STL_P_ALLOC, 16'h0100, 1'b1);
      {int_f, int_r} = {10'h320, 10'h320};
      wr(STL_P_INT_FWD, 16'h0320, 1'b0);
      wr(STL_P_INT_REV, 16'h0320, 1'b0);
      wr(STL_P_FUNC_SEL, 16'h0001, 1'b0);
      settle(2);
      cmp({15'h0000, analog_mode_active}, 16'h0000);
      restart(1'b1);
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         mv <= (i == 0) ? -16'sd1500 : 16'sd1500;
         settle(2);
         wait_tick();
         settle(TICKS - 6);
         cmp({6'h00, analog_limit}, 16'h0032);
         chk_lim(10'h032);
      end
      @(posedge clk);
      ctrl_mode <= STL_MODE_TORQUE;
      chk_lim(10'h3FF);
      @(posedge clk);
      ctrl_mode <= STL_MODE_POSITION;
      chk_lim(10'h3FF);
      @(posedge clk);
      ctrl_mode <= STL_MODE_SPEED;
      wr(STL_P_FILTER_TC, 16'h0001, 1'b0);
      wait_tick();
      @(posedge clk);
      mv <= 16'sd3000;
      wait_tick();
      settle(TICKS - 6);
      cmp({6'h00, analog_limit}, 16'h004B);
      wr(STL_P_FUNC_SEL, 16'h0000, 1'b0);
      restart(1'b0);
      stop_test();
   end
endmodule // servo_torque_limit_select_bench
